// ==== include/nav_frame_pkg.sv ====
// Constants shared by the frame sequencer, its serial transmitter and its divider.
// Assumes a single 125 MHz system clock; every time is turned into cycles or frame ticks here.
package nav_frame_pkg;

  // ==========================================================================
  // Clock and serial line
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BAUD_BPS = 921600;
  // Nearest whole count; 136 cycles give a rate within 0.3 percent of nominal.
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int unsigned DATA_BITS = 8;

  // ==========================================================================
  // Frame timing
  localparam int unsigned FRAME_HZ = 200;
  localparam int unsigned FRAME_CYC = CLK_HZ / FRAME_HZ;
  localparam int unsigned SEQ_PERIOD_MS = 10;
  localparam int unsigned FRAME_PERIOD_MS = 1000 / FRAME_HZ;
  localparam int unsigned SEQ_DIV = SEQ_PERIOD_MS / FRAME_PERIOD_MS;

  // ==========================================================================
  // Operating phase durations, counted in frame ticks
  localparam int unsigned SELFTEST_S = 10;
  localparam int unsigned SELFTEST_TICKS = SELFTEST_S * FRAME_HZ;
  localparam int unsigned ALIGN_MIN = 5;
  localparam int unsigned ALIGN_TICKS = ALIGN_MIN * 60 * FRAME_HZ;

  // ==========================================================================
  // Frame layout
  localparam int unsigned FRAME_BYTES = 49;
  localparam int unsigned IDX_W = 6;
  localparam logic [7:0] HDR_LO = 8'h55;
  localparam logic [7:0] HDR_HI = 8'haa;
  localparam logic [31:0] SEQ_RESET = 32'h0000_0000;

  // ==========================================================================
  // Operating state codes, as sent in the state byte
  typedef enum logic [7:0] {
    OP_SELFTEST = 8'h00,
    OP_PREP = 8'h01,
    OP_ALIGN = 8'h02,
    OP_NAV = 8'h04
  } op_state_t;

  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_SEND = 1'b1
  } frame_state_t;

endpackage : nav_frame_pkg

// ==== include/char_link_if.sv ====
// Byte handshake between the frame builder and the serial transmitter.
// Assumes both ends share one clock; a byte moves when valid and ready are both high.
`timescale 1ns/100ps
interface char_link_if;
  logic valid;
  logic ready;
  logic [7:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface : char_link_if

// ==== hdl/tick_divider.sv ====
// Free-running divider that emits a one-cycle enable pulse every PERIOD clocks.
// Assumes PERIOD is at least 2.
`timescale 1ns/100ps
module tick_divider #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  logic [31:0] cnt_r;
  logic at_end;

  assign at_end = (cnt_r == 32'(PERIOD - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
    end else if (at_end) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= at_end;
    end
  end

endmodule : tick_divider

// ==== hdl/serial_char_tx.sv ====
// Asynchronous character transmitter: one start bit, eight data bits LSB first,
// no parity and no stop bit. Characters may follow back to back.
// Assumes the clock rate in the package; the line idles high between frames.
`timescale 1ns/100ps
module serial_char_tx (
  input wire logic clk,
  input wire logic rst_n,
  char_link_if.snk link,
  output logic tx_line
);

  logic active_r;
  logic [7:0] cyc_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic bit_end;
  logic last_bit;
  logic take;

  assign bit_end = active_r && (cyc_r == 8'(nav_frame_pkg::BIT_CYC - 1));
  assign last_bit = bit_end && (bit_r == 4'(nav_frame_pkg::DATA_BITS));
  // With no stop bit the next start bit must follow the last data bit directly.
  assign link.ready = !active_r || last_bit;
  assign take = link.valid && link.ready;

  // ==========================================================================
  // Bit timing and shifting
  // R05: bit period
  // R07: start then eight bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      cyc_r <= 8'h00;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_line <= 1'b1;
    end else if (take) begin
      active_r <= 1'b1;
      cyc_r <= 8'h00;
      bit_r <= 4'h0;
      shift_r <= link.data;
      tx_line <= 1'b0;
    end else if (last_bit) begin
      active_r <= 1'b0;
      cyc_r <= 8'h00;
      tx_line <= 1'b1;
    end else if (bit_end) begin
      cyc_r <= 8'h00;
      bit_r <= bit_r + 4'h1;
      tx_line <= shift_r[0];
      shift_r <= {1'b0, shift_r[7:1]};
    end else if (active_r) begin
      cyc_r <= cyc_r + 8'h01;
    end
  end

endmodule : serial_char_tx

// ==== hdl/nav_output_frame_sequencer.sv ====
// Operating-state sequencer and periodic output frame builder of the navigation unit.
// Assumes one 125 MHz clock, synchronous inputs, and a decoded north-finding command pulse.
//
// Notes on behaviour
// R01: Self-test about ten seconds, then preparation.
// R02: North-finding command accepted in preparation only.
// R03: Alignment lasts five minutes, then navigation.
// R04: Outputs valid only in navigation state.
// R05: Serial line runs at 921600 bits per second.
// R06: One frame begins every 5 ms.
// R07: Start bit, eight data bits, no parity/stop.
// R08: Header 0x55 then 0xAA at bytes 0-1.
// R09: Bytes 2-5: counter, plus one per 10 ms.
// R10: Byte 6 holds the operating state code.
// R11: Bytes 7-8: fault word, 1 means normal.
// R12: Bytes 9-32: raw gyro and accelerometer increments.
// R13: Bytes 33-48: compensated angle and X velocity.
// R14: Multi-byte fields sent least significant byte first.
// R15: Command is one event; ignored outside preparation.
`timescale 1ns/100ps
module nav_output_frame_sequencer #(
  parameter int unsigned FRAME_CYC = nav_frame_pkg::FRAME_CYC,
  parameter int unsigned SELFTEST_TICKS = nav_frame_pkg::SELFTEST_TICKS,
  parameter int unsigned ALIGN_TICKS = nav_frame_pkg::ALIGN_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic north_cmd,
  input wire logic [15:0] fault_ok,
  input wire logic [31:0] gyro_raw_x,
  input wire logic [31:0] gyro_raw_y,
  input wire logic [31:0] gyro_raw_z,
  input wire logic [31:0] acc_raw_x,
  input wire logic [31:0] acc_raw_y,
  input wire logic [31:0] acc_raw_z,
  input wire logic [31:0] comp_ang_x,
  input wire logic [31:0] comp_ang_y,
  input wire logic [31:0] comp_ang_z,
  input wire logic [31:0] comp_vel_x,
  output logic tx_line,
  output logic [7:0] op_code,
  output logic nav_valid,
  output logic frame_busy
);

  localparam int unsigned FRAME_W = nav_frame_pkg::FRAME_BYTES * 8;

  nav_frame_pkg::op_state_t op_r;
  nav_frame_pkg::frame_state_t fr_r;
  logic [31:0] phase_cnt_r;
  logic [31:0] seq_r;
  logic [3:0] seq_div_r;
  logic [FRAME_W-1:0] snap_r;
  logic [nav_frame_pkg::IDX_W-1:0] idx_r;
  logic frame_tick;
  logic byte_take;
  logic last_byte;

  char_link_if link ();

  // ==========================================================================
  // Frame rate enable
  // R06: 5 ms frame tick
  tick_divider #(
    .PERIOD(FRAME_CYC)
  ) u_frame_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(frame_tick)
  );

  // ==========================================================================
  // Operating state sequence
  // Phase lengths are counted in frame ticks, so the alignment may end up to
  // one frame period early; the self-test starts with the divider and ends on time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= nav_frame_pkg::OP_SELFTEST;
      phase_cnt_r <= 32'h0000_0000;
    end else begin
      unique case (op_r)
        nav_frame_pkg::OP_SELFTEST: begin
          // R01: timed self-test exit
          if (frame_tick) begin
            if (phase_cnt_r == 32'(SELFTEST_TICKS - 1)) begin
              op_r <= nav_frame_pkg::OP_PREP;
              phase_cnt_r <= 32'h0000_0000;
            end else begin
              phase_cnt_r <= phase_cnt_r + 32'h0000_0001;
            end
          end
        end
        nav_frame_pkg::OP_PREP: begin
          // R02: command accepted here
          // R15: single event accept
          if (north_cmd) begin
            op_r <= nav_frame_pkg::OP_ALIGN;
            phase_cnt_r <= 32'h0000_0000;
          end
        end
        nav_frame_pkg::OP_ALIGN: begin
          // R03: timed alignment exit
          if (frame_tick) begin
            if (phase_cnt_r == 32'(ALIGN_TICKS - 1)) begin
              op_r <= nav_frame_pkg::OP_NAV;
              phase_cnt_r <= 32'h0000_0000;
            end else begin
              phase_cnt_r <= phase_cnt_r + 32'h0000_0001;
            end
          end
        end
        nav_frame_pkg::OP_NAV: begin
          phase_cnt_r <= 32'h0000_0000;
        end
        default: begin
          op_r <= nav_frame_pkg::OP_SELFTEST;
          phase_cnt_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign op_code = op_r;
  // R04: valid only in navigation
  assign nav_valid = (op_r == nav_frame_pkg::OP_NAV);

  // ==========================================================================
  // Frame sequence counter
  // R09: plus one per 10 ms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= nav_frame_pkg::SEQ_RESET;
      seq_div_r <= 4'h0;
    end else if (frame_tick) begin
      if (seq_div_r == 4'(nav_frame_pkg::SEQ_DIV - 1)) begin
        seq_div_r <= 4'h0;
        seq_r <= seq_r + 32'h0000_0001;
      end else begin
        seq_div_r <= seq_div_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Frame capture and byte walk
  // A tick that arrives before a frame's last byte is handed over is skipped rather
  // than queued; at the real rates a frame takes about a tenth of the period.
  assign byte_take = link.valid && link.ready;
  assign last_byte = (idx_r == nav_frame_pkg::IDX_W'(nav_frame_pkg::FRAME_BYTES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= nav_frame_pkg::FR_IDLE;
      idx_r <= '0;
    end else begin
      unique case (fr_r)
        nav_frame_pkg::FR_IDLE: begin
          // R06: start frame on tick
          if (frame_tick) begin
            fr_r <= nav_frame_pkg::FR_SEND;
            idx_r <= '0;
          end
        end
        nav_frame_pkg::FR_SEND: begin
          if (byte_take) begin
            if (last_byte) begin
              fr_r <= nav_frame_pkg::FR_IDLE;
            end else begin
              idx_r <= idx_r + nav_frame_pkg::IDX_W'(1);
            end
          end
        end
      endcase
    end
  end

  // Fields are packed with byte 0 in the low bits, so each word leaves LSB first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= '0;
    end else if (frame_tick && (fr_r == nav_frame_pkg::FR_IDLE)) begin
      // R14: least significant byte first
      // R13: compensated increments
      // R12: raw increments
      // R11: fault word
      // R10: state code
      // R09: sequence count
      // R08: two-byte header
      snap_r <= {comp_vel_x, comp_ang_z, comp_ang_y, comp_ang_x,
                 acc_raw_z, acc_raw_y, acc_raw_x,
                 gyro_raw_z, gyro_raw_y, gyro_raw_x,
                 fault_ok, op_r, seq_r,
                 nav_frame_pkg::HDR_HI, nav_frame_pkg::HDR_LO};
    end
  end

  assign link.valid = (fr_r == nav_frame_pkg::FR_SEND);
  assign link.data = snap_r[idx_r * 8 +: 8];
  assign frame_busy = (fr_r == nav_frame_pkg::FR_SEND);

  // ==========================================================================
  // Serial line
  // R05: line bit rate
  // R07: character format
  serial_char_tx u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .link(link),
    .tx_line(tx_line)
  );

endmodule : nav_output_frame_sequencer

// ==== dv/nav_output_frame_sequencer_properties.sv ====
// Port checker of the output frame sequencer.
// Assumes one clock and the package bit period; attached by bind below.
`timescale 1ns/100ps
module nav_seq_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic north_cmd,
  input wire logic tx_line,
  input wire logic [7:0] op_code,
  input wire logic nav_valid,
  input wire logic frame_busy
);
  // ====================
  // Helper counters
  localparam int unsigned BUSY_N = 48 * 9 * nav_frame_pkg::BIT_CYC;
  int unsigned busy_r;
  int unsigned idle_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 0;
    end else begin
      busy_r <= frame_busy ? busy_r + 1 : 0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 0;
    end else begin
      idle_r <= frame_busy ? 0 : (idle_r < 1300 ? idle_r + 1 : idle_r);
    end
  end
  // ====================
  // Properties
  nav_flag_a: assert property (nav_valid == (op_code == 8'h04))
    else $error("nav flag does not follow state");
  state_code_a: assert property (op_code inside {8'h00, 8'h01, 8'h02, 8'h04})
    else $error("illegal state code");
  cmd_accept_a: assert property (op_code == 8'h01 && north_cmd |=> op_code == 8'h02)
    else $error("command not taken in preparation");
  prep_hold_a: assert property (op_code == 8'h01 && !north_cmd |=> op_code == 8'h01)
    else $error("preparation left without command");
  selftest_exit_a: assert property (op_code == 8'h00 |=> op_code inside {8'h00, 8'h01})
    else $error("self-test left wrongly");
  align_exit_a: assert property (op_code == 8'h02 |=> op_code inside {8'h02, 8'h04})
    else $error("alignment left wrongly");
  nav_hold_a: assert property (op_code == 8'h04 |=> op_code == 8'h04)
    else $error("navigation state left");
  start_bit_a: assert property ($rose(frame_busy) |-> tx_line ##1 !tx_line [*8])
    else $error("start bit missing after frame start");
  // A few cycles of slack cover where the builder hands over the last byte.
  frame_len_a: assert property ($fell(frame_busy) |-> busy_r inside {[BUSY_N-8:BUSY_N+8]})
    else $error("frame length wrong");
  line_idle_a: assert property (idle_r >= 1300 |-> tx_line)
    else $error("line not idle high");
  frame_c: cover property ($rose(frame_busy));
  align_c: cover property (op_code == 8'h02);
  nav_c: cover property (op_code == 8'h04);
endmodule : nav_seq_checker

bind nav_output_frame_sequencer nav_seq_checker chk (
  .clk(clk), .rst_n(rst_n), .north_cmd(north_cmd), .tx_line(tx_line),
  .op_code(op_code), .nav_valid(nav_valid), .frame_busy(frame_busy)
);

// ==== dv/host_rx_model.sv ====
// Host receiver model: decodes characters off the serial output line.
// Assumes the line idles high and characters follow with no stop bit.
`timescale 1ns/100ps
module host_rx_model #(
  parameter int unsigned BIT_CYC = 136
) (
  input wire logic clk,
  input wire logic rx_line,
  output logic [7:0] rx_bytes [0:63],
  output int rx_count
);
  logic [7:0] shift;
  initial begin
    rx_count = 0;
    forever begin
      @(negedge rx_line);
      repeat (BIT_CYC / 2) @(posedge clk);
      while (rx_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          shift[i] = rx_line;
        end
        rx_bytes[rx_count[5:0]] = shift;
        rx_count++;
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  end
endmodule : host_rx_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the output frame sequencer with a host receiver.
// Assumes the bound checker; short phase counts keep the run brief.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t: got %h want %h", $time, g, e); end end
module tb_top;
  // ====================
  // Signals
  // The frame period must exceed one whole frame, or ticks are skipped.
  // Extra room leaves the line idle long enough to check it between frames.
  localparam int unsigned FC = 62000;
  logic clk;
  logic rst_n;
  logic north_cmd;
  logic [15:0] fault_ok;
  logic [31:0] fld [0:9];
  logic tx_line;
  logic [7:0] op_code;
  logic nav_valid;
  logic frame_busy;
  logic [7:0] rx_bytes [0:63];
  int rx_count;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int rel;
  nav_output_frame_sequencer #(.FRAME_CYC(FC), .SELFTEST_TICKS(1), .ALIGN_TICKS(1)) uut (
    .clk(clk), .rst_n(rst_n), .north_cmd(north_cmd), .fault_ok(fault_ok),
    .gyro_raw_x(fld[0]), .gyro_raw_y(fld[1]), .gyro_raw_z(fld[2]),
    .acc_raw_x(fld[3]), .acc_raw_y(fld[4]), .acc_raw_z(fld[5]),
    .comp_ang_x(fld[6]), .comp_ang_y(fld[7]), .comp_ang_z(fld[8]),
    .comp_vel_x(fld[9]), .tx_line(tx_line), .op_code(op_code),
    .nav_valid(nav_valid), .frame_busy(frame_busy)
  );
  host_rx_model #(.BIT_CYC(nav_frame_pkg::BIT_CYC)) host (
    .clk(clk), .rx_line(tx_line), .rx_bytes(rx_bytes), .rx_count(rx_count)
  );
  // ====================
  // Tasks
  task automatic test_done();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic pulse_cmd();
    @(posedge clk);
    #1 north_cmd = 1'b1;
    @(posedge clk);
    #1 north_cmd = 1'b0;
  endtask : pulse_cmd
  task automatic wait_op(input logic [7:0] code);
    int n;
    n = 0;
    while (op_code !== code && n < FC + 10) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_op
  task automatic t_selftest();
    @(posedge clk);
    #1;
    `CHK({op_code, nav_valid, frame_busy, tx_line}, 11'h001)
    pulse_cmd();
    `CHK(op_code, 8'h00)
    wait_op(8'h01);
    `CHK((cyc - rel >= FC) && (cyc - rel <= FC + 3), 1'b1)
  endtask : t_selftest
  task automatic t_align();
    pulse_cmd();
    `CHK({op_code, nav_valid}, 9'h004)
    pulse_cmd();
    `CHK(op_code, 8'h02)
  endtask : t_align
  task automatic t_frame();
    logic [7:0] exp;
    int n;
    n = 0;
    while (rx_count < 49 && n < FC + 10) begin
      @(posedge clk);
      n++;
    end
    repeat (300) @(posedge clk);
    #1;
    `CHK({rx_count == 49, frame_busy, tx_line}, 3'b101)
    // Input words carry their own byte positions, so order faults show.
    for (int p = 0; p < 49; p++) begin
      exp = 8'(p);
      if (p == 0) exp = 8'h55;
      else if (p == 1) exp = 8'haa;
      else if (p < 7) exp = 8'h00;
      else if (p == 7) exp = fault_ok[7:0];
      else if (p == 8) exp = fault_ok[15:8];
      `CHK(rx_bytes[p], exp)
    end
  endtask : t_frame
  task automatic t_nav();
    wait_op(8'h04);
    `CHK({op_code, nav_valid}, 9'h009)
    pulse_cmd();
    `CHK(op_code, 8'h04)
  endtask : t_nav
  // ====================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  initial begin
    repeat (200000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    north_cmd = 1'b0;
    fault_ok = 16'h5ac3;
    for (int i = 0; i < 10; i++) begin
      fld[i] = {8'(12 + 4 * i), 8'(11 + 4 * i), 8'(10 + 4 * i), 8'(9 + 4 * i)};
    end
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    rel = cyc;
    t_selftest();
    t_align();
    t_frame();
    t_nav();
    test_done();
  end
endmodule : tb_top
